// ==== design/ds3_alarm_pkg.sv ====
// Constants and types shared by the DS3 transmit alarm override stage.
// Assumes a 32-bit AHB-Lite register port and a bit-serial framed stream.
`default_nettype none

package ds3_alarm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned       ADDR_W          = 12;
    // Registers are counted in words, so the byte address is four times
    // the register's index.
    localparam logic [11:0]       CFG_INDEX       = 12'h030;
    localparam logic [11:0]       CFG_OFFSET      = {CFG_INDEX[9:0], 2'b00};
    localparam logic [11:0]       STATUS_OFFSET   = 12'h004;
    localparam int unsigned       CFG_W           = 8;
    localparam logic [7:0]        CFG_RESET       = 8'h2b;

    // ------------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------------
    localparam int unsigned       BIT_YELLOW      = 7;
    localparam int unsigned       BIT_X_HIGH      = 6;
    localparam int unsigned       BIT_IDLE        = 5;
    localparam int unsigned       BIT_AIS         = 4;
    localparam int unsigned       BIT_ZERO        = 3;
    localparam int unsigned       BIT_FAIL_LOS    = 2;
    localparam int unsigned       BIT_FAIL_OOF    = 1;
    localparam int unsigned       BIT_FAIL_AIS    = 0;

    // ------------------------------------------------------------------
    // Payload patterns, sent most significant bit first
    // ------------------------------------------------------------------
    localparam logic [3:0]        IDLE_PATTERN    = 4'hc;
    localparam logic [3:0]        AIS_PATTERN     = 4'ha;
    localparam logic [1:0]        PHASE_LAST      = 2'h3;

    // ------------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]        HTRANS_NONSEQ   = 2'h2;
    localparam logic              HRESP_OKAY      = 1'h0;

    // Class of the bit presented on the stream in a given cycle.
    typedef enum logic [2:0] {
        KIND_PAYLOAD = 3'h0,
        KIND_X       = 3'h1,
        KIND_M       = 3'h2,
        KIND_F       = 3'h3,
        KIND_P       = 3'h4,
        KIND_CP      = 3'h5,
        KIND_C       = 3'h6,
        KIND_OTHER   = 3'h7
    } bit_kind_t;

    // Resolved override mode, Gray coded along rising priority.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_X_HIGH = 3'h1,
        MODE_YELLOW = 3'h3,
        MODE_IDLE   = 3'h2,
        MODE_AIS    = 3'h6,
        MODE_ZERO   = 3'h7
    } mode_t;

endpackage

`default_nettype wire

// ==== design/ds3_tx_alarm_override.sv ====
// DS3 transmit alarm and maintenance pattern override stage.
// Assumes an upstream framer that tags each bit with its class and marks
// the first bit of each frame, and a receive section giving status levels.
//
// Notes on behaviour
// - Force-X-high (bit 6) sends every X-bit as 1; payload untouched.
// - Otherwise X-bits follow near-end receive conditions.
// - Force-X-high ignored under yellow, alarm-indication, idle or zero.
// - Idle (bit 5) sends X as 1, subframe 3 CP-bits 0, M/F/P valid.
// - Idle replaces payload with repeating 1100.
// - Idle ignored under alarm-indication or zero-signal.
// - Alarm-indication (bit 4) sends X as 1, all C-bits 0, M/F/P valid.
// - Alarm-indication replaces payload with repeating 1010.
// - Alarm-indication ignored under zero-signal.
// - Zero-signal (bit 3) drives every overhead and payload bit to 0.
// - Zero-signal overrides every other control bit.
// - Without override, overhead and payload pass from their sources.
// - Bit 2 enables yellow alarm while receiver reports loss of signal.
// - Bit 1 enables yellow alarm while receiver reports out-of-frame.
// - Bit 0 enables yellow alarm while receiver sees alarm-indication.
// - Yellow alarm forces X-bits 0, payload passes; software bit 7.
// - Software yellow ignored under idle, alarm-indication or zero.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none

module ds3_tx_alarm_override (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic                       in_valid,
    input  wire logic                       in_bit,
    input  wire ds3_alarm_pkg::bit_kind_t   in_kind,
    input  wire logic                       in_frame_start,
    input  wire logic                       rx_signal_loss,
    input  wire logic                       rx_frame_loss,
    input  wire logic                       rx_alarm_indication,
    output logic                            out_valid,
    output logic                            out_bit,
    output ds3_alarm_pkg::bit_kind_t        out_kind,
    output logic                            out_frame_start
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [7:0]                      cfg_q;
    logic                            wr_pend_q;
    logic [11:0]                     wr_addr_q;
    logic [31:0]                     rdata_q;
    logic                            addr_phase;
    logic [11:0]                     addr_lo;
    logic [31:0]                     rd_word;
    logic [31:0]                     status_word;
    logic                            cfg_write;

    assign addr_phase = hsel && hready && htrans[1];
    assign addr_lo    = haddr[ds3_alarm_pkg::ADDR_W-1:0];
    assign cfg_write  = wr_pend_q && (wr_addr_q == ds3_alarm_pkg::CFG_OFFSET);
    assign rd_word    =
        (addr_lo == ds3_alarm_pkg::CFG_OFFSET)    ? {24'h000000, cfg_q} :
        (addr_lo == ds3_alarm_pkg::STATUS_OFFSET) ? status_word :
        32'h00000000;
    assign hreadyout  = 1'b1;
    assign hresp      = ds3_alarm_pkg::HRESP_OKAY;
    assign hrdata     = rdata_q;

    // Writes land in the data phase, so a read right behind a write sees
    // the old value; the window is one cycle and software never polls it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            rdata_q   <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_q <= addr_lo;
            end
            if (addr_phase && !hwrite) begin
                rdata_q <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= ds3_alarm_pkg::CFG_RESET;
        end else if (cfg_write) begin
            cfg_q <= hwdata[ds3_alarm_pkg::CFG_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode resolution
    // ------------------------------------------------------------------
    logic                            want_yellow;
    logic                            want_x_high;
    logic                            want_idle;
    logic                            want_ais;
    logic                            want_zero;
    ds3_alarm_pkg::mode_t            mode;

    assign want_yellow = cfg_q[ds3_alarm_pkg::BIT_YELLOW];
    assign want_x_high = cfg_q[ds3_alarm_pkg::BIT_X_HIGH];
    assign want_idle   = cfg_q[ds3_alarm_pkg::BIT_IDLE];
    assign want_ais    = cfg_q[ds3_alarm_pkg::BIT_AIS];
    assign want_zero   = cfg_q[ds3_alarm_pkg::BIT_ZERO];

    // Priority chain: zero, alarm-indication, idle, yellow, X high.
    assign mode =
        want_zero   ? ds3_alarm_pkg::MODE_ZERO   :
        want_ais    ? ds3_alarm_pkg::MODE_AIS    :
        want_idle   ? ds3_alarm_pkg::MODE_IDLE   :
        want_yellow ? ds3_alarm_pkg::MODE_YELLOW :
        want_x_high ? ds3_alarm_pkg::MODE_X_HIGH :
        ds3_alarm_pkg::MODE_NORMAL;

    // ------------------------------------------------------------------
    // Automatic remote failure indication
    // ------------------------------------------------------------------
    logic                            fail_now;
    logic                            auto_q;
    logic                            auto_frame;

    assign fail_now =
        (cfg_q[ds3_alarm_pkg::BIT_FAIL_LOS] && rx_signal_loss)
        || (cfg_q[ds3_alarm_pkg::BIT_FAIL_OOF] && rx_frame_loss)
        || (cfg_q[ds3_alarm_pkg::BIT_FAIL_AIS] && rx_alarm_indication);

    // Sampled once per frame so both X-bits of a frame always agree.
    assign auto_frame = (in_valid && in_frame_start) ? fail_now : auto_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_q <= 1'b0;
        end else begin
            auto_q <= auto_frame;
        end
    end

    // ------------------------------------------------------------------
    // Payload pattern phase
    // ------------------------------------------------------------------
    logic [1:0]                      phase_q;
    logic                            is_payload;
    logic                            idle_bit;
    logic                            ais_bit;

    assign is_payload = (in_kind == ds3_alarm_pkg::KIND_PAYLOAD);
    assign idle_bit   = ds3_alarm_pkg::IDLE_PATTERN[
        ds3_alarm_pkg::PHASE_LAST - phase_q];
    assign ais_bit    = ds3_alarm_pkg::AIS_PATTERN[
        ds3_alarm_pkg::PHASE_LAST - phase_q];

    // The pattern runs on across overhead gaps and frame edges.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 2'h0;
        end else if (in_valid && is_payload) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Bit selection
    // ------------------------------------------------------------------
    logic                            is_x;
    logic                            is_c;
    logic                            x_bit;
    logic                            bit_d;

    assign is_x  = (in_kind == ds3_alarm_pkg::KIND_X);
    assign is_c  = (in_kind == ds3_alarm_pkg::KIND_CP)
                || (in_kind == ds3_alarm_pkg::KIND_C);

    assign x_bit =
        (mode == ds3_alarm_pkg::MODE_X_HIGH) ? 1'b1 :
        (mode == ds3_alarm_pkg::MODE_YELLOW) ? 1'b0 :
        !auto_frame;

    always_comb begin
        bit_d = in_bit;
        case (mode)
            ds3_alarm_pkg::MODE_ZERO: begin
                bit_d = 1'b0;
            end
            ds3_alarm_pkg::MODE_AIS: begin
                if (is_payload) begin
                    bit_d = ais_bit;
                end else if (is_x) begin
                    bit_d = 1'b1;
                end else if (is_c) begin
                    bit_d = 1'b0;
                end
            end
            ds3_alarm_pkg::MODE_IDLE: begin
                if (is_payload) begin
                    bit_d = idle_bit;
                end else if (is_x) begin
                    bit_d = 1'b1;
                end else if (in_kind == ds3_alarm_pkg::KIND_CP) begin
                    bit_d = 1'b0;
                end
            end
            default: begin
                if (is_x) begin
                    bit_d = x_bit;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid       <= 1'b0;
            out_bit         <= 1'b0;
            out_kind        <= ds3_alarm_pkg::KIND_PAYLOAD;
            out_frame_start <= 1'b0;
        end else begin
            out_valid       <= in_valid;
            out_frame_start <= in_valid && in_frame_start;
            if (in_valid) begin
                out_bit  <= bit_d;
                out_kind <= in_kind;
            end
        end
    end

    assign status_word = {24'h000000, mode, auto_q, rx_alarm_indication,
                          rx_frame_loss, rx_signal_loss, 1'b0};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_x_high;
        in_valid && is_x && want_x_high && !want_yellow && !want_idle
        && !want_ais && !want_zero |=> out_bit;
    endproperty
    a_x_high: assert property (p_x_high) else $error("X-bit not high");

    property p_x_normal;
        in_valid && is_x && mode == ds3_alarm_pkg::MODE_NORMAL
        |=> out_bit == !$past(auto_frame);
    endproperty
    a_x_normal: assert property (p_x_normal) else $error("X-bit wrong");

    property p_priority;
        want_zero |-> mode == ds3_alarm_pkg::MODE_ZERO;
    endproperty
    a_priority: assert property (p_priority) else $error("zero lost");

    property p_ais_over_idle;
        want_ais && want_idle && !want_zero
        |-> mode == ds3_alarm_pkg::MODE_AIS;
    endproperty
    a_ais_over_idle: assert property (p_ais_over_idle)
        else $error("idle beat ais");

    property p_idle_cp;
        in_valid && in_kind == ds3_alarm_pkg::KIND_CP
        && mode == ds3_alarm_pkg::MODE_IDLE |=> !out_bit;
    endproperty
    a_idle_cp: assert property (p_idle_cp) else $error("idle CP set");

    property p_idle_pat;
        in_valid && is_payload && mode == ds3_alarm_pkg::MODE_IDLE
        && phase_q == 2'h0 |=> out_bit;
    endproperty
    a_idle_pat: assert property (p_idle_pat) else $error("idle pattern");

    property p_ais_c;
        in_valid && is_c && mode == ds3_alarm_pkg::MODE_AIS |=> !out_bit;
    endproperty
    a_ais_c: assert property (p_ais_c) else $error("ais C-bit set");

    property p_ais_pat;
        in_valid && is_payload && mode == ds3_alarm_pkg::MODE_AIS
        && phase_q == 2'h1 |=> !out_bit;
    endproperty
    a_ais_pat: assert property (p_ais_pat) else $error("ais pattern");

    property p_zero;
        in_valid && want_zero |=> !out_bit && out_valid;
    endproperty
    a_zero: assert property (p_zero) else $error("zero signal bit");

    property p_pass;
        in_valid && !is_x && mode == ds3_alarm_pkg::MODE_YELLOW
        |=> out_bit == $past(in_bit);
    endproperty
    a_pass: assert property (p_pass) else $error("data altered");

    property p_auto_los;
        in_valid && in_frame_start && rx_signal_loss
        && cfg_q[ds3_alarm_pkg::BIT_FAIL_LOS] |=> auto_q;
    endproperty
    a_auto_los: assert property (p_auto_los)
        else $error("no auto yellow");

    property p_auto_hold;
        !(in_valid && in_frame_start) |=> auto_q == $past(auto_q);
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("auto yellow moved mid-frame");

endmodule

`default_nettype wire

// ==== testbench/ds3_line_sink.sv ====
// Line-side receiver model that takes every outbound bit and counts it.
// Assumes one bit per cycle in which the override stage raises out_valid.
`default_nettype none

module ds3_line_sink (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        out_valid,
    input  wire logic        out_bit,
    input  wire logic        out_frame_start,
    output logic      [15:0] bit_count_q,
    output logic      [15:0] frame_count_q,
    output logic             last_bit_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------------------------------
    // Capture
    // -----------------------------------------------------------------
    // The line side cannot stall the framer, so it never refuses a bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_count_q   <= 16'h0000;
            frame_count_q <= 16'h0000;
            last_bit_q    <= 1'b0;
        end else if (out_valid) begin
            bit_count_q   <= bit_count_q + 16'h0001;
            frame_count_q <= frame_count_q + {15'h0000, out_frame_start};
            last_bit_q    <= out_bit;
        end
    end
endmodule

`default_nettype wire

// ==== testbench/tb_ds3_tx_alarm_override.sv ====
// Self-checking bench for the DS3 transmit alarm override stage.
// Assumes a zero-wait AHB-Lite slave and a one-cycle stream latency.
`default_nettype none

module tb_ds3_tx_alarm_override;
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic                     hclk = 1'b0;
    logic                     hresetn;
    logic                     hsel;
    logic              [31:0] haddr;
    logic              [1:0]  htrans;
    logic                     hwrite;
    logic              [2:0]  hsize;
    logic              [31:0] hwdata;
    logic                     hready;
    logic              [31:0] hrdata;
    logic                     hreadyout;
    logic                     hresp;
    logic                     in_valid;
    logic                     in_bit;
    ds3_alarm_pkg::bit_kind_t in_kind;
    logic                     in_frame_start;
    logic              [2:0]  rx_cond;
    logic                     out_valid;
    logic                     out_bit;
    ds3_alarm_pkg::bit_kind_t out_kind;
    logic                     out_frame_start;
    logic              [15:0] bit_count_q;
    logic              [15:0] frame_count_q;
    logic              [7:0]  cfg;
    logic              [31:0] rd;
    logic                     au;
    logic              [1:0]  ph;
    int                       sent;
    int                       frames;
    int                       err_count;
    int                       n_tests;
    logic              [2:0]  seq_k [12] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5,
        3'h6, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    logic              [7:0]  cfgs [13] = '{8'h00, 8'h40, 8'hc0, 8'h80,
        8'h20, 8'ha0, 8'h60, 8'h30, 8'h70, 8'h10, 8'h18, 8'h08, 8'hf8};

    localparam logic   [31:0] CFG_ADDR = {20'h00000, ds3_alarm_pkg::CFG_OFFSET};

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    ds3_tx_alarm_override u_ds3_tx_alarm_override (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .in_valid(in_valid), .in_bit(in_bit),
        .in_kind(in_kind), .in_frame_start(in_frame_start),
        .rx_signal_loss(rx_cond[2]), .rx_frame_loss(rx_cond[1]),
        .rx_alarm_indication(rx_cond[0]), .out_valid(out_valid),
        .out_bit(out_bit), .out_kind(out_kind),
        .out_frame_start(out_frame_start));

    ds3_line_sink u_ds3_line_sink (
        .hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
        .out_bit(out_bit), .out_frame_start(out_frame_start),
        .bit_count_q(bit_count_q), .frame_count_q(frame_count_q),
        .last_bit_q());

    // -----------------------------------------------------------------
    // Reference and checks
    // -----------------------------------------------------------------
    function automatic logic ref_bit(input logic [7:0] c,
        input ds3_alarm_pkg::bit_kind_t k, input logic b, input logic a,
        input logic [1:0] p);
        logic pay;
        pay = (k == ds3_alarm_pkg::KIND_PAYLOAD);
        if (c[3]) return 1'b0;
        if (c[4]) begin
            if (k == ds3_alarm_pkg::KIND_X) return 1'b1;
            if (k == ds3_alarm_pkg::KIND_CP) return 1'b0;
            if (k == ds3_alarm_pkg::KIND_C) return 1'b0;
            return pay ? ds3_alarm_pkg::AIS_PATTERN[~p] : b;
        end
        if (c[5]) begin
            if (k == ds3_alarm_pkg::KIND_X) return 1'b1;
            if (k == ds3_alarm_pkg::KIND_CP) return 1'b0;
            return pay ? ds3_alarm_pkg::IDLE_PATTERN[~p] : b;
        end
        if (k != ds3_alarm_pkg::KIND_X) return b;
        if (c[7]) return 1'b0;
        return c[6] ? 1'b1 : !a;
    endfunction

    task automatic chk_reg(input string n, input logic [31:0] e,
                           input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask

    // -----------------------------------------------------------------
    // Bus and stream drivers
    // -----------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= ds3_alarm_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk_bit("hresp", ds3_alarm_pkg::HRESP_OKAY, hresp);
    endtask

    task automatic wr_cfg(input logic [7:0] c);
        ahb(1'b1, CFG_ADDR, {24'hffffff, c});
        cfg = c;
        ahb(1'b0, CFG_ADDR, 32'h0000_0000);
        chk_reg("config", {24'h000000, c}, rd);
    endtask

    task automatic send(input ds3_alarm_pkg::bit_kind_t k, input logic b,
                        input logic fs);
        logic e;
        @(posedge hclk);
        in_valid       <= 1'b1;
        in_kind        <= k;
        in_bit         <= b;
        in_frame_start <= fs;
        if (fs) begin
            au = |(cfg[2:0] & rx_cond);
            frames++;
        end
        e = ref_bit(cfg, k, b, au, ph);
        if (k == ds3_alarm_pkg::KIND_PAYLOAD) ph++;
        sent++;
        @(posedge hclk);
        in_valid       <= 1'b0;
        in_frame_start <= 1'b0;
        #1;
        chk_bit("out_bit", e, out_bit);
        chk_reg("out_kind", {29'h0, k}, {29'h0, out_kind});
        chk_bit("out_frame_start", fs, out_frame_start);
    endtask

    task automatic frame(input logic [11:0] b);
        for (int i = 0; i < 12; i++) begin
            send(ds3_alarm_pkg::bit_kind_t'(seq_k[i]), b[i], i == 0);
        end
    endtask

    task automatic set_rx(input logic [2:0] v);
        @(posedge hclk);
        rx_cond <= v;
    endtask

    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Sequence
    // -----------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        in_valid = 1'b0;
        in_bit = 1'b0;
        in_kind = ds3_alarm_pkg::KIND_PAYLOAD;
        in_frame_start = 1'b0;
        rx_cond = 3'h0;
        cfg = 8'h2b;
        au = 1'b0;
        ph = 2'h0;
        sent = 0;
        frames = 0;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, CFG_ADDR, 32'h0);
        chk_reg("config reset", 32'h0000_002b, rd);
        ahb(1'b0, 32'h0000_0004, 32'h0);
        chk_reg("status reset", 32'h0000_00e0, rd);
        frame(12'hfff);
        ahb(1'b1, 32'h0000_0004, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0004, 32'h0);
        chk_reg("status ro", 32'h0000_00e0, rd);
        ahb(1'b0, 32'h0000_0008, 32'h0);
        chk_reg("unmapped", 32'h0000_0000, rd);
        // Every mode and seven overlaps, with both bit polarities on each slot.
        foreach (cfgs[i]) begin
            wr_cfg(cfgs[i]);
            frame(12'ha5c);
            frame(12'h5a3);
        end
        // Each receive condition, with its enable off and then on.
        for (int k = 0; k < 3; k++) begin
            for (int en = 0; en < 2; en++) begin
                wr_cfg(en ? (8'h01 << k) : (8'h07 & ~(8'h01 << k)));
                set_rx(3'b001 << k);
                frame(12'hfff);
            end
        end
        // An automatic alarm lasts to the end of the frame that took it.
        send(ds3_alarm_pkg::KIND_X, 1'b1, 1'b1);
        set_rx(3'h0);
        send(ds3_alarm_pkg::KIND_X, 1'b1, 1'b0);
        frame(12'h000);
        // The sink counts the last bit one edge after it appears.
        @(posedge hclk);
        #1;
        chk_reg("line bits", sent, {16'h0, bit_count_q});
        chk_reg("line frames", frames, {16'h0, frame_count_q});
        test_done();
    end

    // The planned traffic needs well under a tenth of this span.
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done();
    end
endmodule

`default_nettype wire
